// ==== rtl/baud_timer.sv ====
// Third timer/counter working as serial baud-rate generator, with register port and interrupt
`default_nettype none
module baud_timer (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic write_i,
  input wire logic read_i,
  input wire logic external_count_pin_i,
  input wire logic external_trigger_pin_i,
  input wire logic power_down_i,
  output logic [7:0] rdata_o,
  output logic irq_o,
  output logic baud_tick_o,
  output logic baud_ext_tick_o
);

  // ****************************************
  // State
  // ****************************************
  baud_timer_pkg::timer_state_t s_r;
  baud_timer_pkg::timer_state_t s_nxt;
  baud_timer_pkg::reg_req_t req;
  logic count_fall;
  logic trigger_fall;

  assign req = '{addr: addr_i, wdata: wdata_i, wr: write_i, rd: read_i};

  // ****************************************
  // Pin edge detection
  // ****************************************
  // Both pins use the same detector against the sample held in the state struct
  pin_fall_detect pin_fall_detect_count_inst (
    .armed_i(s_r.ctrl.run_bit & ~power_down_i),
    .prev_i(s_r.count_pin_prev),
    .pin_i(external_count_pin_i),
    .fall_o(count_fall)
  );
  pin_fall_detect pin_fall_detect_trigger_inst (
    .armed_i(~power_down_i),
    .prev_i(s_r.trigger_pin_prev),
    .pin_i(external_trigger_pin_i),
    .fall_o(trigger_fall)
  );

  always_comb begin
    logic baud_mode;
    logic run;
    logic step;
    logic [15:0] count;
    logic rollover;
    logic trig_fall;
    logic [baud_timer_pkg::IRQ_WIDTH-1:0] ev;
    baud_mode = 1'b0;
    run = 1'b0;
    step = 1'b0;
    count = 16'h0000;
    rollover = 1'b0;
    trig_fall = 1'b0;
    ev = '0;
    s_nxt = s_r;
    s_nxt.baud_tick = 1'b0;
    s_nxt.baud_ext_tick = 1'b0;

    baud_mode = s_r.ctrl.receive_clock_select & s_r.ctrl.transmit_clock_select;
    // Power-down freezes everything but the read port in place; idle is not seen here at all
    run = s_r.ctrl.run_bit & ~power_down_i;

    // One step per state time internally, or per falling count-pin edge
    if (!power_down_i) begin
      s_nxt.state_div = (s_r.state_div == baud_timer_pkg::STATE_DIV_LAST) ? 1'b0 : s_r.state_div + 1'b1;
      s_nxt.count_pin_prev = external_count_pin_i;
      s_nxt.trigger_pin_prev = external_trigger_pin_i;
    end
    if (s_r.ctrl.counter_timer_select) begin
      step = count_fall;
    end else begin
      step = run & (s_r.state_div == baud_timer_pkg::STATE_DIV_LAST);
    end

    count = {s_r.count_high_byte, s_r.count_low_byte};
    if (step) begin
      rollover = (count == 16'hFFFF);
      if (rollover && baud_mode) begin
        {s_nxt.count_high_byte, s_nxt.count_low_byte} = {s_r.reload_high_byte, s_r.reload_low_byte};
      end else begin
        {s_nxt.count_high_byte, s_nxt.count_low_byte} = count + 16'h0001;
      end
    end

    trig_fall = trigger_fall;

    // Register writes first, so hardware events below win over a clear
    if (req.wr) begin
      unique case (req.addr)
        baud_timer_pkg::ADDR_CONTROL: s_nxt.ctrl = req.wdata;
        baud_timer_pkg::ADDR_COUNT_LOW: s_nxt.count_low_byte = req.wdata;
        baud_timer_pkg::ADDR_COUNT_HIGH: s_nxt.count_high_byte = req.wdata;
        baud_timer_pkg::ADDR_RELOAD_LOW: s_nxt.reload_low_byte = req.wdata;
        baud_timer_pkg::ADDR_RELOAD_HIGH: s_nxt.reload_high_byte = req.wdata;
        baud_timer_pkg::ADDR_IRQ_ENABLE: s_nxt.irq_enable = req.wdata[baud_timer_pkg::IRQ_WIDTH-1:0];
        baud_timer_pkg::ADDR_IRQ_CLEAR: s_nxt.irq_status = s_r.irq_status & ~req.wdata[baud_timer_pkg::IRQ_WIDTH-1:0];
        default: ;
      endcase
    end

    // Overflow flag only outside baud mode
    if (rollover && !baud_mode) begin
      s_nxt.ctrl.overflow_flag = 1'b1;
      ev[baud_timer_pkg::IRQ_OVERFLOW] = 1'b1;
    end
    if (trig_fall && s_r.ctrl.external_trigger_enable) begin
      s_nxt.ctrl.external_trigger_flag = 1'b1;
      ev[baud_timer_pkg::IRQ_TRIGGER] = 1'b1;
    end
    if (rollover && baud_mode) begin
      s_nxt.baud_tick = 1'b1;
      ev[baud_timer_pkg::IRQ_RELOAD] = 1'b1;
      // Serial port divides by 16 in counter mode; a divided tick is offered too
      s_nxt.ext_div = s_r.ext_div + 4'h1;
      s_nxt.baud_ext_tick = (s_r.ext_div == 4'(baud_timer_pkg::BAUD_TICK_DIV - 1));
    end
    s_nxt.irq_status = s_nxt.irq_status | ev;

    s_nxt.rdata = 8'h00;
    if (req.rd) begin
      unique case (req.addr)
        baud_timer_pkg::ADDR_CONTROL: s_nxt.rdata = s_r.ctrl;
        baud_timer_pkg::ADDR_COUNT_LOW: s_nxt.rdata = s_r.count_low_byte;
        baud_timer_pkg::ADDR_COUNT_HIGH: s_nxt.rdata = s_r.count_high_byte;
        baud_timer_pkg::ADDR_RELOAD_LOW: s_nxt.rdata = s_r.reload_low_byte;
        baud_timer_pkg::ADDR_RELOAD_HIGH: s_nxt.rdata = s_r.reload_high_byte;
        baud_timer_pkg::ADDR_IRQ_STATUS: s_nxt.rdata = {5'h00, s_r.irq_status};
        baud_timer_pkg::ADDR_IRQ_ENABLE: s_nxt.rdata = {5'h00, s_r.irq_enable};
        default: s_nxt.rdata = 8'h00;
      endcase
    end
    s_nxt.irq = |(s_nxt.irq_status & s_nxt.irq_enable);

    // Stopped oscillator: every register holds, a pending tick included;
    // only the read port idles at zero since no access can complete
    if (power_down_i) begin
      s_nxt = s_r;
      s_nxt.rdata = 8'h00;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_r <= '{ctrl: baud_timer_pkg::CONTROL_RESET,
               count_high_byte: baud_timer_pkg::COUNT_RESET[15:8],
               count_low_byte: baud_timer_pkg::COUNT_RESET[7:0],
               reload_high_byte: baud_timer_pkg::RELOAD_RESET[15:8],
               reload_low_byte: baud_timer_pkg::RELOAD_RESET[7:0],
               irq_status: baud_timer_pkg::IRQ_RESET,
               irq_enable: baud_timer_pkg::IRQ_RESET,
               state_div: 1'b0,
               count_pin_prev: 1'b1,
               trigger_pin_prev: 1'b1,
               ext_div: 4'h0,
               rdata: 8'h00,
               irq: 1'b0,
               baud_tick: 1'b0,
               baud_ext_tick: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata_o = s_r.rdata;
  assign irq_o = s_r.irq;
  assign baud_tick_o = s_r.baud_tick;
  assign baud_ext_tick_o = s_r.baud_ext_tick;

endmodule

// ****************************************
// Falling-edge detector
// ****************************************
// Combinational only, so the owner keeps the pin sample in its own state
module pin_fall_detect (
  input wire logic armed_i,
  input wire logic prev_i,
  input wire logic pin_i,
  output logic fall_o
);

  assign fall_o = armed_i & prev_i & ~pin_i;

endmodule
`default_nettype wire

// ==== shared/baud_timer_pkg.sv ====
// Constants, register map and carrier types for the baud-rate timer block
// Behaviour
// - Receive and transmit clock selects both set put the timer in baud generator mode.
// - In baud mode a high-byte rollover leaves the overflow flag and interrupt untouched; the code sets the reload interrupt status bit instead.
// - In baud mode every rollover reloads both count bytes from the reload bytes.
// - In baud mode the trigger pin still serves software as an extra interrupt source.
// - Internal timer function in baud mode advances the count once every state time.
// - Counting from the count pin, baud rate is overflow rate divided by 16.
// - Counting internally, baud rate is oscillator over 32 times the reload-derived count.
// - The timer holds a 16-bit count.
// - Idle mode halts only the core; the timer keeps running.
// - Power-down stops the clock so the timer halts; stored state is retained.
// - A control bit selects internal timer events or external pin events.
// - With trigger enable set, a falling trigger-pin edge sets the external flag.
`default_nettype none
package baud_timer_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_COUNT_LOW = 4'h1;
  localparam logic [3:0] ADDR_COUNT_HIGH = 4'h2;
  localparam logic [3:0] ADDR_RELOAD_LOW = 4'h3;
  localparam logic [3:0] ADDR_RELOAD_HIGH = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h5;
  localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h6;
  localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h7;

  // ****************************************
  // Control register bit positions
  // ****************************************
  localparam int BIT_OVERFLOW_FLAG = 7;
  localparam int BIT_TRIGGER_FLAG = 6;
  localparam int BIT_RECEIVE_SEL = 5;
  localparam int BIT_TRANSMIT_SEL = 4;
  localparam int BIT_TRIGGER_EN = 3;
  localparam int BIT_RUN = 2;
  localparam int BIT_COUNTER_SEL = 1;

  // Status, enable and clear bit layout
  localparam int IRQ_OVERFLOW = 0;
  localparam int IRQ_TRIGGER = 1;
  localparam int IRQ_RELOAD = 2;
  localparam int IRQ_WIDTH = 3;

  // ****************************************
  // Reset values and timing
  // ****************************************
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  localparam int OSC_PER_STATE = 2;
  localparam logic [0:0] STATE_DIV_LAST = 1'(OSC_PER_STATE - 1);
  localparam int BAUD_TICK_DIV = 16;

  typedef struct packed {
    logic overflow_flag;
    logic external_trigger_flag;
    logic receive_clock_select;
    logic transmit_clock_select;
    logic external_trigger_enable;
    logic run_bit;
    logic counter_timer_select;
    logic spare;
  } third_timer_control_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    third_timer_control_t ctrl;
    logic [7:0] count_high_byte;
    logic [7:0] count_low_byte;
    logic [7:0] reload_high_byte;
    logic [7:0] reload_low_byte;
    logic [IRQ_WIDTH-1:0] irq_status;
    logic [IRQ_WIDTH-1:0] irq_enable;
    logic state_div;
    logic count_pin_prev;
    logic trigger_pin_prev;
    logic [3:0] ext_div;
    logic [7:0] rdata;
    logic irq;
    logic baud_tick;
    logic baud_ext_tick;
  } timer_state_t;

endpackage
`default_nettype wire

// ==== tb/baud_timer_chk.sv ====
// Port checker for the baud-rate timer
`default_nettype none
module baud_timer_chk (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic write_i,
  input wire logic read_i,
  input wire logic external_count_pin_i,
  input wire logic external_trigger_pin_i,
  input wire logic power_down_i,
  input wire logic [7:0] rdata_o,
  input wire logic irq_o,
  input wire logic baud_tick_o,
  input wire logic baud_ext_tick_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!reset_n_i);
  // ****
  // Port relations
  // ****
  chk_read_idle: assert property (!$past(read_i) |-> rdata_o == 8'h00)
    else $error("read data without read");
  chk_unmapped_read: assert property (read_i && addr_i[3] |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  // A frozen clock may hold a tick high, so power-down lifts the width checks
  chk_tick_single: assert property (disable iff (!reset_n_i || power_down_i) baud_tick_o |=> !baud_tick_o)
    else $error("baud tick too long");
  chk_ext_single: assert property (disable iff (!reset_n_i || power_down_i) baud_ext_tick_o |=> !baud_ext_tick_o)
    else $error("ext tick too long");
  chk_ext_tick_pair: assert property (baud_ext_tick_o |-> baud_tick_o || $past(baud_tick_o))
    else $error("ext tick without reload");
  chk_power_freeze: assert property ($past(power_down_i) |-> $stable({irq_o, baud_tick_o, baud_ext_tick_o}))
    else $error("outputs moved in power-down");
  chk_run_stop: assert property (write_i && addr_i == 4'h0 && (wdata_i & 8'h34) != 8'h34 |-> ##3 !baud_tick_o [*2])
    else $error("tick outside baud mode");
  chk_irq_off: assert property (write_i && addr_i == 4'h6 && wdata_i == 8'h00 ##1 !write_i |=> !irq_o)
    else $error("irq with enables off");
  cover property (baud_tick_o);
  cover property (baud_ext_tick_o);
  cover property ($rose(irq_o));
endmodule
bind baud_timer baud_timer_chk baud_timer_chk_inst (.clock_i(clock_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i), .external_count_pin_i(external_count_pin_i),
  .external_trigger_pin_i(external_trigger_pin_i), .power_down_i(power_down_i), .rdata_o(rdata_o),
  .irq_o(irq_o), .baud_tick_o(baud_tick_o), .baud_ext_tick_o(baud_ext_tick_o));
`default_nettype wire

// ==== tb/serial_port_model.sv ====
// Serial port stand-in that counts baud ticks and measures their spacing
`default_nettype none
module serial_port_model (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic baud_tick_i,
  input wire logic baud_ext_tick_i,
  output logic [15:0] tick_count_o,
  output logic [15:0] tick_period_o,
  output logic [15:0] ext_period_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] since_tick;
  logic [15:0] since_ext;
  logic tick_prev;
  logic ext_prev;
  logic tick_rise;
  logic ext_rise;
  // Edges, not levels: a tick held by a stopped clock counts once
  assign tick_rise = baud_tick_i & ~tick_prev;
  assign ext_rise = baud_ext_tick_i & ~ext_prev;
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      {tick_count_o, tick_period_o, ext_period_o, since_tick, since_ext, tick_prev, ext_prev} <= '0;
    end else begin
      tick_prev <= baud_tick_i;
      ext_prev <= baud_ext_tick_i;
      since_tick <= tick_rise ? 16'h0001 : since_tick + 16'h0001;
      since_ext <= ext_rise ? 16'h0001 : since_ext + 16'h0001;
      if (tick_rise) begin
        tick_count_o <= tick_count_o + 16'h0001;
        tick_period_o <= since_tick;
      end
      if (ext_rise) begin
        ext_period_o <= since_ext;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/baud_timer_tb.sv ====
// Self-checking bench for the baud-rate timer
`default_nettype none
module baud_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic write_i = 1'b0;
  logic read_i = 1'b0;
  logic trig_pin = 1'b1;
  logic power_down_i = 1'b0;
  logic pin_run = 1'b0;
  logic [1:0] pin_div = 2'h0;
  logic [7:0] rdata_o;
  logic irq_o, baud_tick_o, baud_ext_tick_o;
  logic [15:0] tick_count, tick_period, ext_period, mark;
  int errors = 0;
  int num_checks = 0;
  logic [19:0] rows [8] = '{{4'h3, 8'hA5, 8'hA5}, {4'h4, 8'h5A, 8'h5A}, {4'h1, 8'h3C, 8'h3C}, {4'h2, 8'hC3, 8'hC3},
    {4'h6, 8'hFF, 8'h07}, {4'h5, 8'hFF, 8'h00}, {4'h9, 8'hFF, 8'h00}, {4'h0, 8'h0A, 8'h0A}};
  always #50 clock_i = ~clock_i;
  // Count pin falls once every four clocks while enabled
  always @(posedge clock_i) if (pin_run) pin_div <= pin_div + 2'h1;
  baud_timer baud_timer_inst (.clock_i(clock_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .write_i(write_i), .read_i(read_i), .external_count_pin_i(pin_run ? pin_div[1] : 1'b1),
    .external_trigger_pin_i(trig_pin), .power_down_i(power_down_i), .rdata_o(rdata_o), .irq_o(irq_o),
    .baud_tick_o(baud_tick_o), .baud_ext_tick_o(baud_ext_tick_o));
  serial_port_model serial_port_model_inst (.clock_i(clock_i), .reset_n_i(reset_n_i), .baud_tick_i(baud_tick_o),
    .baud_ext_tick_i(baud_ext_tick_o), .tick_count_o(tick_count), .tick_period_o(tick_period),
    .ext_period_o(ext_period));
  // ****
  // Bus and compare tasks
  // ****
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_i);
    write_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
    write_i <= 1'b0;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock_i);
    read_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    read_i <= 1'b0;
    @(negedge clock_i);
    check({8'h00, rdata_o}, {8'h00, e});
    @(posedge clock_i);
  endtask
  task automatic wait_clocks(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic conclude();
    if (errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #5_000_000 errors++;
    conclude();
  end
  initial begin
    wait_clocks(10);
    reset_n_i <= 1'b1;
    @(negedge clock_i);
    check({rdata_o, 5'h00, irq_o, baud_tick_o, baud_ext_tick_o}, 16'h0000);
    rdchk(4'h0, baud_timer_pkg::CONTROL_RESET);
    foreach (rows[i]) begin
      wr(rows[i][19:16], rows[i][15:8]);
      rdchk(rows[i][19:16], rows[i][7:0]);
    end
    // Reload of FFFE gives two steps per rollover
    wr(4'h3, 8'hFE);
    wr(4'h4, 8'hFF);
    wr(4'h1, 8'hFE);
    wr(4'h2, 8'hFF);
    wr(4'h6, 8'h04);
    wr(4'h0, 8'h34);
    wait_clocks(200);
    check(tick_period, 16'(2 * baud_timer_pkg::OSC_PER_STATE));
    check(ext_period, 16'(2 * baud_timer_pkg::OSC_PER_STATE * baud_timer_pkg::BAUD_TICK_DIV));
    check({15'h0000, irq_o}, 16'h0001);
    rdchk(4'h0, 8'h34);
    power_down_i <= 1'b1;
    wait_clocks(3);
    mark = tick_count;
    wait_clocks(40);
    check(tick_count, mark);
    power_down_i <= 1'b0;
    wait_clocks(20);
    check({15'h0000, tick_count > mark}, 16'h0001);
    wr(4'h0, 8'h36);
    pin_run <= 1'b1;
    wait_clocks(400);
    check(tick_period, 16'h0008);
    check(ext_period, 16'h0080);
    pin_run <= 1'b0;
    wr(4'h0, 8'h30);
    rdchk(4'h5, 8'h04);
    mark = tick_count;
    wr(4'h7, 8'h07);
    wait_clocks(20);
    check({tick_count[14:0], irq_o}, {mark[14:0], 1'b0});
    wr(4'h6, 8'h02);
    wr(4'h0, 8'h38);
    trig_pin <= 1'b0;
    wait_clocks(4);
    check({15'h0000, irq_o}, 16'h0001);
    rdchk(4'h0, 8'h78);
    trig_pin <= 1'b1;
    wr(4'h6, 8'h00);
    wait_clocks(3);
    check({15'h0000, irq_o}, 16'h0000);
    // Plain timer: rollover sets the overflow flag and gives no tick
    wr(4'h7, 8'h07);
    wr(4'h6, 8'h01);
    wr(4'h1, 8'hFE);
    wr(4'h2, 8'hFF);
    wr(4'h0, 8'h00);
    mark = tick_count;
    wr(4'h0, 8'h04);
    wait_clocks(12);
    check({15'h0000, irq_o}, 16'h0001);
    rdchk(4'h0, 8'h84);
    rdchk(4'h5, 8'h01);
    check(tick_count, mark);
    wr(4'h0, 8'h00);
    // Reset after the timer is stopped
    reset_n_i <= 1'b0;
    wait_clocks(2);
    reset_n_i <= 1'b1;
    @(negedge clock_i);
    check({rdata_o, 5'h00, irq_o, baud_tick_o, baud_ext_tick_o}, 16'h0000);
    rdchk(4'h1, 8'h00);
    rdchk(4'h0, baud_timer_pkg::CONTROL_RESET);
    conclude();
  end
endmodule
`default_nettype wire
